// ===== bus_lock_tracker.sv
`timescale 1ns/1ns
// What this block does
// - Only one locked sequence may be in progress at any time.
// - Locks only pair the partition upstream port with one own downstream port.
// - Lock is established only by a successful locked completion with data.
// - Upstream MRdLk is forwarded and locks its downstream port against other sources.
// - Blocking touches only TLPs mapped to VC0 at the egress port.
// - MRdLk waits for queued posted requests to its port; passes completions.
// - A locked downstream port stalls no traffic to other ports except a second MRdLk.
// - CplDLk from locked port is forwarded, locks upstream port, partition bus-locked.
// - CplDLk waits for posted requests queued from that port; passes non-posted.
// - Side-band register path stays usable during bus lock.
// - Further MRdLk, CplDLk, CplLk and MWr leave bus lock unchanged.
// - Locked ports may still insert their own messages and MSIs.
// - Upstream Unlock clears lock, goes to locked port, releases both ports.
// - Posted requests queued from upstream finish before the lock is left.
// - An Unlock is ignored when it is not from upstream or no lock is in progress.
// - Blocked TLPs are held, never dropped, until unlock.
module bus_lock_tracker (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // Partition layout
    input wire logic [bus_lock_pkg::PORT_BITS-1:0] up_port_i,
    input wire logic [bus_lock_pkg::PORT_COUNT-1:0] member_i,
    // Presented TLP
    input wire logic tlp_valid_i,
    input wire logic [bus_lock_pkg::PORT_BITS-1:0] tlp_src_i,
    input wire logic [bus_lock_pkg::PORT_BITS-1:0] tlp_dst_i,
    input wire bus_lock_pkg::tlp_kind_type tlp_kind_i,
    input wire logic tlp_vc0_i,
    // Posted queue occupancy
    input wire logic [bus_lock_pkg::PORT_COUNT-1:0] posted_to_pend_i,
    input wire logic [bus_lock_pkg::PORT_COUNT-1:0] posted_from_pend_i,
    // Decision
    output logic tlp_ack_o,
    output logic tlp_held_o,
    // Lock status
    output logic [bus_lock_pkg::PORT_COUNT-1:0] locked_mask_o,
    output logic [bus_lock_pkg::PORT_BITS-1:0] locked_dn_o,
    output logic bus_locked_o,
    output logic unlock_fwd_o,
    output logic cfg_hold_o
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        bus_lock_pkg::lock_state_type st;
        logic [bus_lock_pkg::PORT_BITS-1:0] dn;
        logic [bus_lock_pkg::PORT_COUNT-1:0] mask;
        logic ack;
        logic held;
        logic unlock_fwd;
        logic bus_lock;
    } lock_regs_type;

    lock_regs_type r;
    lock_regs_type next_r;
    logic gate_hold;
    logic from_up;
    logic from_dn;
    logic to_dn;
    logic dst_member;
    logic up_drained;
    logic take;
    logic [bus_lock_pkg::PORT_COUNT-1:0] up_bit;
    logic [bus_lock_pkg::PORT_COUNT-1:0] dst_bit;

    // ------------------------------------------------------------
    // Egress blocking check
    // ------------------------------------------------------------
    lock_block_gate u_gate (
        .locked_mask_i(r.mask),
        .up_port_i(up_port_i),
        .dn_port_i(r.dn),
        .src_i(tlp_src_i),
        .dst_i(tlp_dst_i),
        .vc0_i(tlp_vc0_i),
        .insert_i(tlp_kind_i == bus_lock_pkg::KIND_INSERT),
        .hold_o(gate_hold)
    );

    assign from_up = (tlp_src_i == up_port_i);
    assign from_dn = (tlp_src_i == r.dn);
    assign to_dn = (tlp_dst_i == r.dn);
    assign dst_member = member_i[tlp_dst_i];
    assign up_bit = bus_lock_pkg::PORT_COUNT'(1) << up_port_i;
    assign dst_bit = bus_lock_pkg::PORT_COUNT'(1) << tlp_dst_i;
    assign up_drained = !posted_from_pend_i[up_port_i];
    // The source keeps valid up during the acknowledge cycle, so skip it
    assign take = tlp_valid_i && !r.ack;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_r = r;
        next_r.ack = 1'b0;
        next_r.held = 1'b0;
        next_r.unlock_fwd = 1'b0;
        if (take) begin
            // Blocked TLPs wait in place; nothing here ever discards them
            next_r.held = 1'b1;
            case (tlp_kind_i)
                bus_lock_pkg::KIND_MRDLK: begin
                    if (!from_up || !dst_member || tlp_dst_i == up_port_i) begin
                        // Not a lock request of this partition: ordinary read
                        next_r.held = gate_hold;
                        next_r.ack = !gate_hold;
                    end else if (r.st == bus_lock_pkg::LOCK_IDLE) begin
                        next_r.st = bus_lock_pkg::LOCK_REQ_DRAIN;
                        next_r.dn = tlp_dst_i;
                        next_r.mask = dst_bit;
                    end else if (r.st == bus_lock_pkg::LOCK_REQ_DRAIN) begin
                        // Only posted writes ahead of it count; completions are overtaken
                        if (!posted_to_pend_i[r.dn]) begin
                            next_r.st = bus_lock_pkg::LOCK_DN_LOCKED;
                            next_r.held = 1'b0;
                            next_r.ack = 1'b1;
                        end
                    end else if (to_dn && (r.st == bus_lock_pkg::LOCK_BUS_LOCKED
                                           || r.st == bus_lock_pkg::LOCK_DN_LOCKED)) begin
                        // Repeat locked read to the same device keeps the lock as it is
                        if (!posted_to_pend_i[r.dn]) begin
                            next_r.held = 1'b0;
                            next_r.ack = 1'b1;
                        end
                    end
                    // A second lock to another port stays held until unlock
                end
                bus_lock_pkg::KIND_CPLDLK: begin
                    if (r.st == bus_lock_pkg::LOCK_DN_LOCKED && from_dn) begin
                        next_r.st = bus_lock_pkg::LOCK_CPL_DRAIN;
                    end else if (r.st == bus_lock_pkg::LOCK_CPL_DRAIN && from_dn) begin
                        // Posted writes from the locked port go out first
                        if (!posted_from_pend_i[r.dn]) begin
                            next_r.st = bus_lock_pkg::LOCK_BUS_LOCKED;
                            next_r.mask = r.mask | up_bit;
                            next_r.held = 1'b0;
                            next_r.ack = 1'b1;
                        end
                    end else begin
                        next_r.held = gate_hold;
                        next_r.ack = !gate_hold;
                    end
                end
                bus_lock_pkg::KIND_UNLOCK: begin
                    if (!from_up || r.st == bus_lock_pkg::LOCK_IDLE) begin
                        // No lock to release: let it through untouched
                        next_r.held = 1'b0;
                        next_r.ack = 1'b1;
                    end else if (r.st == bus_lock_pkg::LOCK_UNLOCK_DRAIN) begin
                        if (up_drained) begin
                            next_r.st = bus_lock_pkg::LOCK_IDLE;
                            next_r.mask = bus_lock_pkg::RESET_MASK;
                            next_r.held = 1'b0;
                            next_r.ack = 1'b1;
                            next_r.unlock_fwd = 1'b1;
                        end
                    end else begin
                        next_r.st = bus_lock_pkg::LOCK_UNLOCK_DRAIN;
                    end
                end
                default: begin
                    // CplLk, MWr, messages and the rest follow the egress blocks
                    next_r.held = gate_hold;
                    next_r.ack = !gate_hold;
                end
            endcase
        end else if (!tlp_valid_i && r.st == bus_lock_pkg::LOCK_REQ_DRAIN) begin
            // Request withdrawn before it went out: no lock was ever made
            next_r.st = bus_lock_pkg::LOCK_IDLE;
            next_r.mask = bus_lock_pkg::RESET_MASK;
        end
        // Only a completed lock counts, so unlocking a failed lock never flags bus lock
        next_r.bus_lock = (next_r.st == bus_lock_pkg::LOCK_BUS_LOCKED)
                          || (next_r.st == bus_lock_pkg::LOCK_UNLOCK_DRAIN && r.bus_lock);
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r.st <= bus_lock_pkg::LOCK_IDLE;
            r.dn <= bus_lock_pkg::RESET_PORT;
            r.mask <= bus_lock_pkg::RESET_MASK;
            r.ack <= 1'b0;
            r.held <= 1'b0;
            r.unlock_fwd <= 1'b0;
            r.bus_lock <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign tlp_ack_o = r.ack;
    assign tlp_held_o = r.held;
    assign locked_mask_o = r.mask;
    assign locked_dn_o = r.dn;
    assign bus_locked_o = r.bus_lock;
    assign unlock_fwd_o = r.unlock_fwd;
    // Config completions cannot be made while bus-locked; side-band access stays open
    assign cfg_hold_o = r.bus_lock;

endmodule

// ===== bus_lock_pkg.sv
package bus_lock_pkg;

    // ------------------------------------------------------------
    // Port numbering
    // ------------------------------------------------------------
    localparam int PORT_COUNT = 16;
    localparam int PORT_BITS = 4;

    // ------------------------------------------------------------
    // Kind of a TLP presented for a forwarding decision
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        KIND_OTHER = 3'h0,
        KIND_MWR = 3'h1,
        KIND_MRDLK = 3'h2,
        KIND_CPLDLK = 3'h3,
        KIND_CPLLK = 3'h4,
        KIND_UNLOCK = 3'h5,
        KIND_INSERT = 3'h6
    } tlp_kind_type;

    // ------------------------------------------------------------
    // Lock sequence states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        LOCK_IDLE = 3'h0,
        LOCK_REQ_DRAIN = 3'h1,
        LOCK_DN_LOCKED = 3'h2,
        LOCK_CPL_DRAIN = 3'h3,
        LOCK_BUS_LOCKED = 3'h4,
        LOCK_UNLOCK_DRAIN = 3'h5
    } lock_state_type;

    // ------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------
    localparam logic [PORT_BITS-1:0] RESET_PORT = 4'h0;
    localparam logic [PORT_COUNT-1:0] RESET_MASK = 16'h0000;

endpackage

// ===== lock_block_gate.sv
`timescale 1ns/1ns
module lock_block_gate (
    // Lock view
    input wire logic [bus_lock_pkg::PORT_COUNT-1:0] locked_mask_i,
    input wire logic [bus_lock_pkg::PORT_BITS-1:0] up_port_i,
    input wire logic [bus_lock_pkg::PORT_BITS-1:0] dn_port_i,
    // Presented TLP
    input wire logic [bus_lock_pkg::PORT_BITS-1:0] src_i,
    input wire logic [bus_lock_pkg::PORT_BITS-1:0] dst_i,
    input wire logic vc0_i,
    input wire logic insert_i,
    // Decision
    output logic hold_o
);

    logic [bus_lock_pkg::PORT_COUNT-1:0] hit;

    // ------------------------------------------------------------
    // Per egress port block test
    // ------------------------------------------------------------
    genvar p;
    generate
        for (p = 0; p < bus_lock_pkg::PORT_COUNT; p++) begin : g_port
            logic exempt;
            logic [bus_lock_pkg::PORT_BITS-1:0] own;
            assign own = bus_lock_pkg::PORT_BITS'(p);
            // The partner of a locked port is the only source let through
            assign exempt = (own == dn_port_i) ? (src_i == up_port_i) : (src_i == dn_port_i);
            assign hit[p] = locked_mask_i[p] && (dst_i == own) && !exempt;
        end
    endgenerate

    // Non-VC0 traffic and messages the ports insert themselves never wait
    assign hold_o = vc0_i && !insert_i && (|hit);

endmodule

// ===== bus_lock_sva.sv
`timescale 1ns/1ns
module bus_lock_sva (
    // Clock, reset and layout
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic [3:0] up_port_i,
    input wire logic [15:0] member_i,
    // Presented TLP and queues
    input wire logic tlp_valid_i,
    input wire logic [3:0] tlp_src_i,
    input wire logic [3:0] tlp_dst_i,
    input wire bus_lock_pkg::tlp_kind_type tlp_kind_i,
    input wire logic tlp_vc0_i,
    input wire logic [15:0] posted_to_pend_i,
    input wire logic [15:0] posted_from_pend_i,
    // Decision and status
    input wire logic tlp_ack_o,
    input wire logic tlp_held_o,
    input wire logic [15:0] locked_mask_o,
    input wire logic [3:0] locked_dn_o,
    input wire logic bus_locked_o,
    input wire logic unlock_fwd_o,
    input wire logic cfg_hold_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_lock_take;
        tlp_valid_i && !tlp_ack_o && tlp_kind_i == bus_lock_pkg::KIND_MRDLK && tlp_src_i == up_port_i &&
            member_i[tlp_dst_i] && tlp_dst_i != up_port_i && locked_mask_o == 16'h0000;
    endsequence
    sequence s_blocked;
        tlp_valid_i && !tlp_ack_o && tlp_vc0_i && tlp_kind_i == bus_lock_pkg::KIND_OTHER &&
            locked_mask_o[tlp_dst_i] && tlp_src_i != (tlp_dst_i == up_port_i ? locked_dn_o : up_port_i);
    endsequence
    a_lock_marks_port: assert property (s_lock_take |=> tlp_held_o && locked_mask_o[tlp_dst_i])
        else $error("lock request did not mark its port");
    a_vc0_block: assert property (s_blocked |=> tlp_held_o && !tlp_ack_o)
        else $error("blocked TLP was not held");
    a_free_pass: assert property (tlp_valid_i && !tlp_ack_o && tlp_kind_i == bus_lock_pkg::KIND_OTHER &&
        !(tlp_vc0_i && locked_mask_o[tlp_dst_i]) |-> ##[1:2] tlp_ack_o) else $error("free TLP not forwarded");
    a_cpl_locks_bus: assert property (tlp_ack_o && tlp_kind_i == bus_lock_pkg::KIND_CPLDLK &&
        $past(locked_mask_o[tlp_src_i]) && !$past(bus_locked_o) |-> bus_locked_o && locked_mask_o[up_port_i])
        else $error("locked completion did not lock the bus");
    a_lock_needs_cpl: assert property ($rose(bus_locked_o) |-> tlp_ack_o && tlp_kind_i == bus_lock_pkg::KIND_CPLDLK)
        else $error("bus lock without locked completion");
    a_bus_lock_keeps: assert property ($past(bus_locked_o) && tlp_ack_o && tlp_kind_i != bus_lock_pkg::KIND_UNLOCK
        |-> bus_locked_o && $stable(locked_mask_o)) else $error("bus lock changed without unlock");
    a_unlock_clears: assert property (unlock_fwd_o |-> tlp_ack_o && locked_mask_o == 16'h0000 && !bus_locked_o)
        else $error("unlock did not clear the lock");
    a_unlock_ignored: assert property (tlp_ack_o && $past(locked_mask_o) == 16'h0000 |-> !unlock_fwd_o)
        else $error("unlock forwarded with no lock");
    a_posted_first: assert property (tlp_ack_o |-> !(tlp_kind_i == bus_lock_pkg::KIND_MRDLK &&
        $past(posted_to_pend_i[tlp_dst_i])) && !(tlp_kind_i == bus_lock_pkg::KIND_CPLDLK &&
        $past(posted_from_pend_i[tlp_src_i])) && !(unlock_fwd_o && $past(posted_from_pend_i[up_port_i])))
        else $error("locked TLP passed queued posted requests");
    a_one_lock: assert property ($countones(locked_mask_o) <= 1 ||
        ($countones(locked_mask_o) == 2 && locked_mask_o[up_port_i])) else $error("two lock sequences");
endmodule
bind bus_lock_tracker bus_lock_sva chk_i (.ref_clk_i, .rst_n_i, .up_port_i, .member_i, .tlp_valid_i, .tlp_src_i,
    .tlp_dst_i, .tlp_kind_i, .tlp_vc0_i, .posted_to_pend_i, .posted_from_pend_i, .tlp_ack_o, .tlp_held_o,
    .locked_mask_o, .locked_dn_o, .bus_locked_o, .unlock_fwd_o, .cfg_hold_o);

// ===== tlp_source.sv
`timescale 1ns/1ns
module tlp_source (
    // Clock and answer
    input wire logic ref_clk_i,
    input wire logic tlp_ack_i,
    // Presented TLP
    output logic valid_o,
    output logic [3:0] src_o,
    output logic [3:0] dst_o,
    output bus_lock_pkg::tlp_kind_type kind_o,
    output logic vc0_o
);
    initial begin
        valid_o = 1'b0;
        src_o = 4'h0;
        dst_o = 4'h0;
        kind_o = bus_lock_pkg::KIND_OTHER;
        vc0_o = 1'b0;
    end
    // Never issues configuration requests, so bus lock needs no config path
    task automatic send(input logic [3:0] s, input logic [3:0] d, input bus_lock_pkg::tlp_kind_type k,
                        input logic v, input int lim, output logic acked, output int n);
        acked = 1'b0;
        n = 0;
        @(posedge ref_clk_i);
        valid_o <= 1'b1;
        src_o <= s;
        dst_o <= d;
        kind_o <= k;
        vc0_o <= v;
        while (acked !== 1'b1 && n < lim) begin
            @(posedge ref_clk_i);
            n++;
            acked = (tlp_ack_i === 1'b1);
        end
        // Source and destination flip so a stale value is never mistaken for a live one; kind and VC0 keep their values
        valid_o <= 1'b0;
        src_o <= ~s;
        dst_o <= ~d;
    endtask
endmodule

// ===== tb.sv
`timescale 1ns/1ns
module tb;
    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [3:0] up_port_i = 4'h0;
    logic [15:0] member_i = 16'h00FF;
    logic [15:0] posted_to_pend_i = 16'h0000;
    logic [15:0] posted_from_pend_i = 16'h0000;
    logic tlp_valid_i, tlp_vc0_i, tlp_ack_o, tlp_held_o, bus_locked_o, unlock_fwd_o, cfg_hold_o, acked;
    logic [3:0] tlp_src_i, tlp_dst_i, locked_dn_o;
    logic [15:0] locked_mask_o;
    bus_lock_pkg::tlp_kind_type tlp_kind_i;
    int bad_count = 0;
    int total_checks = 0;
    int fwd_seen = 0;
    int waited;
    bus_lock_tracker dut (.ref_clk_i, .rst_n_i, .up_port_i, .member_i, .tlp_valid_i, .tlp_src_i, .tlp_dst_i,
        .tlp_kind_i, .tlp_vc0_i, .posted_to_pend_i, .posted_from_pend_i, .tlp_ack_o, .tlp_held_o,
        .locked_mask_o, .locked_dn_o, .bus_locked_o, .unlock_fwd_o, .cfg_hold_o);
    tlp_source src_m (.ref_clk_i, .tlp_ack_i(tlp_ack_o), .valid_o(tlp_valid_i), .src_o(tlp_src_i),
        .dst_o(tlp_dst_i), .kind_o(tlp_kind_i), .vc0_o(tlp_vc0_i));
    initial begin
        forever #2 ref_clk_i = ~ref_clk_i;
    end
    always @(negedge ref_clk_i) if (unlock_fwd_o === 1'b1) fwd_seen++;
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask
    task automatic go(input logic [3:0] s, input logic [3:0] d, input bus_lock_pkg::tlp_kind_type k, input logic v);
        src_m.send(s, d, k, v, 12, acked, waited);
    endtask
    task automatic drained(input logic [3:0] s, input logic [3:0] d, input bus_lock_pkg::tlp_kind_type k);
        fork
            go(s, d, k, 1'b1);
            begin
                repeat (4) @(posedge ref_clk_i);
                posted_to_pend_i <= 16'h0000;
                posted_from_pend_i <= 16'h0000;
            end
        join
        chk(acked, 1'b1, "drained TLP forwarded");
        chk(waited > 4, 1'b1, "passed queued posted");
    endtask
    task automatic reset_pulse();
        @(posedge ref_clk_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        chk({tlp_ack_o, tlp_held_o, bus_locked_o, unlock_fwd_o}, 16'h0000, "flags in reset");
        chk(locked_mask_o, 16'h0000, "mask in reset");
        rst_n_i <= 1'b1;
        @(posedge ref_clk_i);
    endtask
    task automatic t_lock();
        bus_lock_pkg::tlp_kind_type ks [5] = '{bus_lock_pkg::KIND_MWR, bus_lock_pkg::KIND_MRDLK,
            bus_lock_pkg::KIND_CPLLK, bus_lock_pkg::KIND_CPLDLK, bus_lock_pkg::KIND_INSERT};
        posted_to_pend_i <= 16'h0008;
        drained(4'h0, 4'h3, bus_lock_pkg::KIND_MRDLK);
        chk(locked_mask_o, 16'h0008, "downstream locked");
        chk(16'(locked_dn_o), 16'h0003, "locked port number");
        chk(bus_locked_o, 1'b0, "no bus lock yet");
        go(4'h5, 4'h6, bus_lock_pkg::KIND_OTHER, 1'b1);
        chk(acked, 1'b1, "peer traffic");
        go(4'h5, 4'h0, bus_lock_pkg::KIND_OTHER, 1'b1);
        chk(acked, 1'b1, "traffic upward");
        go(4'h5, 4'h3, bus_lock_pkg::KIND_OTHER, 1'b0);
        chk(acked, 1'b1, "other channel");
        posted_from_pend_i <= 16'h0008;
        drained(4'h3, 4'h0, bus_lock_pkg::KIND_CPLDLK);
        chk({bus_locked_o, cfg_hold_o}, 16'h0003, "bus locked");
        chk(locked_mask_o, 16'h0009, "both ports locked");
        for (int i = 0; i < 5; i++) begin
            go(i < 2 ? 4'h0 : 4'h3, i < 2 ? 4'h3 : 4'h0, ks[i], 1'b1);
            chk(acked, 1'b1, "locked traffic");
            chk({bus_locked_o, locked_mask_o[14:0]}, 16'h8009, "lock kept");
        end
        posted_from_pend_i <= 16'h0001;
        drained(4'h0, 4'h3, bus_lock_pkg::KIND_UNLOCK);
        chk({bus_locked_o, locked_mask_o[14:0]}, 16'h0000, "unlocked");
        chk(16'(fwd_seen), 16'h0001, "unlock forwarded");
        go(4'h0, 4'h3, bus_lock_pkg::KIND_UNLOCK, 1'b1);
        chk(16'(fwd_seen), 16'h0001, "stray unlock");
        $display("test lock done");
    endtask
    task automatic t_block();
        go(4'h0, 4'h3, bus_lock_pkg::KIND_MRDLK, 1'b1);
        go(4'h5, 4'h3, bus_lock_pkg::KIND_OTHER, 1'b1);
        chk(acked, 1'b0, "blocked TLP held");
        chk(tlp_held_o, 1'b1, "blocked TLP flagged held");
        reset_pulse();
        go(4'h0, 4'h3, bus_lock_pkg::KIND_MRDLK, 1'b1);
        go(4'h0, 4'h6, bus_lock_pkg::KIND_MRDLK, 1'b1);
        chk(acked, 1'b0, "second lock held");
        reset_pulse();
        go(4'h0, 4'h9, bus_lock_pkg::KIND_MRDLK, 1'b1);
        chk(acked, 1'b1, "foreign read forwarded");
        chk(locked_mask_o, 16'h0000, "foreign port not locked");
        posted_to_pend_i <= 16'h0008;
        src_m.send(4'h0, 4'h3, bus_lock_pkg::KIND_MRDLK, 1'b1, 3, acked, waited);
        posted_to_pend_i <= 16'h0000;
        chk(acked, 1'b0, "lock waits for posted");
        repeat (2) @(posedge ref_clk_i);
        chk(locked_mask_o, 16'h0000, "withdrawn lock dropped");
        $display("test block done");
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge ref_clk_i);
        bad_count++;
        wrap_up();
    end
    initial begin
        repeat (6) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        @(posedge ref_clk_i);
        t_lock();
        t_block();
        wrap_up();
    end
endmodule
